// file: src/pmw_defs.svh
// constants for the setpoint pacing and converter result register port
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH
`define PMW_CLK_MHZ          10
`define PMW_I2C_ADDR         7'h2d
`define PMW_NUM_OUT          5
// register offsets
`define PMW_REG_CONV_EN      8'h01
`define PMW_REG_SP_FIRST     8'h10
`define PMW_REG_SP_LAST      8'h14
`define PMW_REG_STATUS       8'h1a
`define PMW_REG_DIE_TEMP     8'h1b
`define PMW_REG_AN_A         8'h1c
`define PMW_REG_AN_B         8'h1d
// reset values
`define PMW_LIN_SP_RST       8'ha5
`define PMW_SW_SP_RST        8'h00
`define PMW_CONV_EN_RST      1'b1
// timing
`define PMW_PACE_NOM_US      2000
`define PMW_PACE_MARGIN_PCT  10
`define PMW_SLEW_MV_PER_US   10
`define PMW_COARSE_STEP_UV   20000
`define PMW_FINE_STEP_UV     6250
// converter source select
`define PMW_SRC_DIE_TEMP     2'h0
`define PMW_SRC_AN_A         2'h1
`define PMW_SRC_AN_B         2'h2
`endif

// file: src/pmw_pkg.sv
// types shared by the pacing port and its output channels
package pmw_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDAT, ST_RDAT, ST_MACK} pmw_i2c_st_t;
  typedef enum logic [1:0] {CV_CAL, CV_IDLE, CV_BUSY} pmw_conv_st_t;
  typedef struct packed {
    logic       stb;
    logic [7:0] data;
  } pmw_wr_t;
endpackage : pmw_pkg

// file: src/pmw_chan.sv
// one output channel: setpoint register, pacing timer, slew ramp, power-ok blanking
`timescale 1ns/1ps
`include "pmw_defs.svh"
module pmw_chan #(
  parameter logic [7:0] RST_CODE = 8'h00,
  parameter int         STEP_CYC = 20,
  parameter int         PACE_CYC = 22000,
  parameter bit         RAMPS    = 1'b1
) (
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  input  wire pmw_pkg::pmw_wr_t wr,
  input  wire logic            pg_raw,
  output logic                 busy,
  output logic [7:0]           setpoint,
  output logic [7:0]           level_ff,
  output logic                 power_ok_ff
);
  localparam int PW = $clog2(PACE_CYC + 1);
  localparam int SW = $clog2(STEP_CYC + 1);
  if (STEP_CYC < 1 || PACE_CYC < 9) begin : g_bad
    $error("pmw_chan: step or pacing count too small");
  end

  logic [7:0]    setpoint_ff;
  logic [PW-1:0] pace_ff;
  logic [SW-1:0] step_ff;
  logic          setpoint_ramping;
  logic          step_due;

  // ================================================================
  // status decode
  assign setpoint_ramping = (level_ff != setpoint_ff);
  assign busy             = (pace_ff != '0) | setpoint_ramping;
  assign setpoint         = setpoint_ff;
  assign step_due         = (step_ff == SW'(STEP_CYC - 1));

  // setpoint store and pacing window restart on an accepted write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      setpoint_ff <= RST_CODE;
      pace_ff     <= '0;
    end else if (wr.stb) begin
      setpoint_ff <= wr.data;
      pace_ff     <= PW'(PACE_CYC);
    end else if (pace_ff != '0) begin
      pace_ff     <= pace_ff - PW'(1);
    end
  end

  // ramp one code per step period, or step at once when not ramping
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level_ff <= RST_CODE;
      step_ff  <= '0;
    end else if (!RAMPS) begin
      level_ff <= setpoint_ff;
    end else if (!setpoint_ramping) begin
      step_ff  <= '0;
    end else if (step_due) begin
      step_ff  <= '0;
      level_ff <= (setpoint_ff > level_ff) ? level_ff + 8'h01 : level_ff - 8'h01;
    end else begin
      step_ff  <= step_ff + SW'(1);
    end
  end

  // power-ok held high while ramping, follows comparator after
  always_ff @(posedge mclk) begin
    if (sys_rst) power_ok_ff <= 1'b0;
    else power_ok_ff <= setpoint_ramping | pg_raw;
  end

  // ================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  refuse_hold_a: assert property (!wr.stb |=> $stable(setpoint_ff))
    else $error("setpoint changed without accepted write");
  no_ramp_write_a: assert property (wr.stb |-> !setpoint_ramping)
    else $error("write accepted during ramp");
  pace_window_a: assert property (wr.stb |=> busy [*8])
    else $error("pacing window not held");
  pace_load_a: assert property (wr.stb |=> pace_ff == PW'(PACE_CYC))
    else $error("pacing timer not loaded with full guard");
  ramp_blank_a: assert property (setpoint_ramping |=> power_ok_ff)
    else $error("power ok not blanked during ramp");
  slew_step_a: assert property (RAMPS && $changed(level_ff) |->
      ((level_ff - $past(level_ff)) == 8'h01 || ($past(level_ff) - level_ff) == 8'h01))
    else $error("ramp moved more than one code");
endmodule : pmw_chan

// file: src/pmw_i2c_pacing.sv
// serial register port with setpoint write pacing and converter result registers
// Function
// - never stretch clock; refuse by not-acknowledge
// - refuse setpoint rewrite within 2.2 ms
// - guard is 2 ms timer plus 10 percent
// - one change per output per window
// - switching outputs ramp at 10 V/ms
// - one converter shared by three sources
// - die temperature code readable at 0x1b
// - analog inputs readable at 0x1c, 0x1d
// - converter enabled, calibrated at power-up
// - refuse setpoint write while ramp unfinished
// - power-ok blanked high while ramping
`timescale 1ns/1ps
`include "pmw_defs.svh"
module pmw_i2c_pacing #(
  parameter int PACE_CYC = ((`PMW_PACE_NOM_US * (100 + `PMW_PACE_MARGIN_PCT)) / 100) * `PMW_CLK_MHZ
) (
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out_ff,
  output logic                               sda_oe_ff,
  input  wire logic [`PMW_NUM_OUT-1:0]       pg_raw,
  output logic [`PMW_NUM_OUT-1:0]            output_power_ok,
  output logic [`PMW_NUM_OUT-1:0][7:0]       vout_level,
  output logic                               conv_cal_ff,
  output logic                               conv_start_ff,
  output logic [1:0]                         conv_src_ff,
  input  wire logic                          conv_done,
  input  wire logic [7:0]                    conv_data
);
  localparam int COARSE_CYC = ((`PMW_COARSE_STEP_UV / `PMW_SLEW_MV_PER_US) * `PMW_CLK_MHZ) / 1000;
  localparam int FINE_CYC   = ((`PMW_FINE_STEP_UV / `PMW_SLEW_MV_PER_US) * `PMW_CLK_MHZ) / 1000;
  if (PACE_CYC < 9) begin : g_bad
    $error("pmw_i2c_pacing: PACE_CYC must be at least 9");
  end

  // setpoint register window decode, used by read and write paths
  function automatic logic sp_hit(input logic [7:0] a);
    sp_hit = (a >= `PMW_REG_SP_FIRST) && (a <= `PMW_REG_SP_LAST);
  endfunction : sp_hit

  logic                          scl_m_ff, scl_s_ff, scl_q_ff;
  logic                          sda_m_ff, sda_s_ff, sda_q_ff;
  logic [`PMW_NUM_OUT-1:0]       pg_m_ff, pg_s_ff;
  pmw_pkg::pmw_i2c_st_t          st_ff;
  pmw_pkg::pmw_conv_st_t         cv_ff;
  logic [7:0]                    shreg_ff, tx_ff, ptr_ff, rd_byte;
  logic [2:0]                    cnt_ff;
  logic                          byte_done_ff, ack_slot_ff, conv_en_ff;
  logic [7:0]                    res_ff [3];
  pmw_pkg::pmw_wr_t              wr_ff [`PMW_NUM_OUT];
  logic [`PMW_NUM_OUT-1:0]       chan_busy, wr_stb_vec;
  logic [`PMW_NUM_OUT-1:0][7:0]  sp_val;
  logic                          scl_rise, scl_fall, start_det, stop_det;
  logic                          wr_byte, ptr_sp, sp_busy, wr_accept;
  logic [2:0]                    sp_idx;

  // ================================================================
  // pin synchronisers, third stage only for edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {scl_m_ff, scl_s_ff, scl_q_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_q_ff} <= 3'h7;
      pg_m_ff <= '0;
      pg_s_ff <= '0;
    end else begin
      {scl_m_ff, scl_s_ff, scl_q_ff} <= {scl_in, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_q_ff} <= {sda_in, sda_m_ff, sda_s_ff};
      pg_m_ff <= pg_raw;
      pg_s_ff <= pg_m_ff;
    end
  end

  // bus event and write decision decode
  assign scl_rise  = scl_s_ff & ~scl_q_ff;
  assign scl_fall  = ~scl_s_ff & scl_q_ff;
  assign start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
  assign stop_det  = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;
  assign wr_byte   = scl_fall & ~ack_slot_ff & byte_done_ff & (st_ff == pmw_pkg::ST_WDAT);
  assign ptr_sp    = sp_hit(ptr_ff);
  assign sp_idx    = ptr_ff[2:0];
  assign sp_busy   = ptr_sp & chan_busy[sp_idx];
  assign wr_accept = ~sp_busy;

  // read data selection
  assign rd_byte = ptr_sp                           ? sp_val[sp_idx] :
                   (ptr_ff == `PMW_REG_CONV_EN)     ? {7'h00, conv_en_ff} :
                   (ptr_ff == `PMW_REG_STATUS)      ? {3'h0, output_power_ok} :
                   (ptr_ff == `PMW_REG_DIE_TEMP)    ? res_ff[`PMW_SRC_DIE_TEMP] :
                   (ptr_ff == `PMW_REG_AN_A)        ? res_ff[`PMW_SRC_AN_A] :
                   (ptr_ff == `PMW_REG_AN_B)        ? res_ff[`PMW_SRC_AN_B] : 8'h00;

  // ================================================================
  // serial slave: sda driven low only, scl never driven
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= pmw_pkg::ST_IDLE;
      shreg_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      cnt_ff <= 3'h0;
      byte_done_ff <= 1'b0;
      ack_slot_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end else if (start_det) begin
      st_ff <= pmw_pkg::ST_ADDR;
      cnt_ff <= 3'h0;
      byte_done_ff <= 1'b0;
      ack_slot_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
      st_ff <= pmw_pkg::ST_IDLE;
      byte_done_ff <= 1'b0;
      ack_slot_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (scl_rise && !ack_slot_ff) begin
      if (st_ff == pmw_pkg::ST_ADDR || st_ff == pmw_pkg::ST_REG || st_ff == pmw_pkg::ST_WDAT) begin
        shreg_ff <= {shreg_ff[6:0], sda_s_ff};
        cnt_ff <= cnt_ff + 3'h1;
        byte_done_ff <= (cnt_ff == 3'h7);
      end else if (st_ff == pmw_pkg::ST_RDAT) begin
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == 3'h7) st_ff <= pmw_pkg::ST_MACK;
      end else if (st_ff == pmw_pkg::ST_MACK) begin
        if (!sda_s_ff) begin  // master wants another byte
          st_ff <= pmw_pkg::ST_RDAT;
          tx_ff <= rd_byte;
          ptr_ff <= ptr_ff + 8'h01;
          ack_slot_ff <= 1'b1;
        end else begin
          st_ff <= pmw_pkg::ST_IDLE;
        end
      end
    end else if (scl_fall) begin
      if (ack_slot_ff) begin  // end of acknowledge slot
        ack_slot_ff <= 1'b0;
        sda_oe_ff <= (st_ff == pmw_pkg::ST_RDAT) ? ~tx_ff[7] : 1'b0;
      end else if (byte_done_ff) begin
        byte_done_ff <= 1'b0;
        ack_slot_ff <= 1'b1;
        if (st_ff == pmw_pkg::ST_ADDR) begin
          if (shreg_ff[7:1] == `PMW_I2C_ADDR) begin
            sda_oe_ff <= 1'b1;
            st_ff <= shreg_ff[0] ? pmw_pkg::ST_RDAT : pmw_pkg::ST_REG;
            if (shreg_ff[0]) tx_ff <= rd_byte;
            if (shreg_ff[0]) ptr_ff <= ptr_ff + 8'h01;
          end else begin
            st_ff <= pmw_pkg::ST_IDLE;
          end
        end else if (st_ff == pmw_pkg::ST_REG) begin
          ptr_ff <= shreg_ff;
          sda_oe_ff <= 1'b1;
          st_ff <= pmw_pkg::ST_WDAT;
        end else begin
          sda_oe_ff <= wr_accept;
          ptr_ff <= ptr_ff + 8'h01;
        end
      end else if (st_ff == pmw_pkg::ST_RDAT) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
        sda_oe_ff <= ~tx_ff[6];
      end else if (st_ff == pmw_pkg::ST_MACK) begin
        sda_oe_ff <= 1'b0;
      end
    end
  end

  // converter enable register and channel write strobes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conv_en_ff <= `PMW_CONV_EN_RST;
      for (int i = 0; i < `PMW_NUM_OUT; i++) wr_ff[i] <= '0;
    end else begin
      if (wr_byte && ptr_ff == `PMW_REG_CONV_EN) conv_en_ff <= shreg_ff[0];
      for (int i = 0; i < `PMW_NUM_OUT; i++) begin
        wr_ff[i].stb <= wr_byte & ptr_sp & wr_accept & (sp_idx == 3'(i));
        wr_ff[i].data <= shreg_ff;
      end
    end
  end

  // ================================================================
  // converter sequencer: calibrate once, then rotate sources
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cv_ff <= pmw_pkg::CV_CAL;
      conv_cal_ff <= 1'b1;
      conv_start_ff <= 1'b0;
      conv_src_ff <= `PMW_SRC_DIE_TEMP;
      for (int i = 0; i < 3; i++) res_ff[i] <= 8'h00;
    end else begin
      unique case (cv_ff)
        pmw_pkg::CV_CAL: begin
          if (conv_done) conv_cal_ff <= 1'b0;
          if (conv_done) cv_ff <= pmw_pkg::CV_IDLE;
        end
        pmw_pkg::CV_IDLE: begin
          conv_start_ff <= conv_en_ff;
          if (conv_en_ff) cv_ff <= pmw_pkg::CV_BUSY;
        end
        pmw_pkg::CV_BUSY: begin
          conv_start_ff <= 1'b0;
          if (conv_done) begin
            res_ff[conv_src_ff] <= conv_data;
            conv_src_ff <= (conv_src_ff == `PMW_SRC_AN_B) ? `PMW_SRC_DIE_TEMP : conv_src_ff + 2'h1;
            cv_ff <= pmw_pkg::CV_IDLE;
          end
        end
      endcase
    end
  end

  // ================================================================
  // output channels: 0 linear, 1-2 coarse switchers, 3-4 fine switchers
  for (genvar g = 0; g < `PMW_NUM_OUT; g++) begin : g_out
    pmw_chan #(
      .RST_CODE ((g == 0) ? `PMW_LIN_SP_RST : `PMW_SW_SP_RST),
      .STEP_CYC ((g >= 3) ? FINE_CYC : COARSE_CYC),
      .PACE_CYC (PACE_CYC),
      .RAMPS    (g != 0)
    ) u_chan (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .wr          (wr_ff[g]),
      .pg_raw      (pg_s_ff[g]),
      .busy        (chan_busy[g]),
      .setpoint    (sp_val[g]),
      .level_ff    (vout_level[g]),
      .power_ok_ff (output_power_ok[g])
    );
    assign wr_stb_vec[g] = wr_ff[g].stb;
  end

  // ================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  nak_refuse_a: assert property (wr_byte && sp_busy |=> !sda_oe_ff && ack_slot_ff && wr_stb_vec == '0)
    else $error("busy setpoint write not refused");
  ack_take_a: assert property (wr_byte && ptr_sp && !sp_busy |=> sda_oe_ff && wr_stb_vec != '0)
    else $error("free setpoint write not taken");
  drive_window_a: assert property (sda_oe_ff |->
      ack_slot_ff || st_ff == pmw_pkg::ST_RDAT || st_ff == pmw_pkg::ST_MACK)
    else $error("sda driven outside ack or read data");
  conv_reset_a: assert property ($past(sys_rst) |-> conv_en_ff && conv_cal_ff)
    else $error("converter not enabled and calibrating after reset");
  cal_first_a: assert property (conv_cal_ff |-> !conv_start_ff)
    else $error("conversion started before calibration");
  temp_store_a: assert property (cv_ff == pmw_pkg::CV_BUSY && conv_done && conv_src_ff == `PMW_SRC_DIE_TEMP
      |=> res_ff[`PMW_SRC_DIE_TEMP] == $past(conv_data) && conv_src_ff == `PMW_SRC_AN_A)
    else $error("temperature result not stored");
  // second analog input conversion finishing, then the rotation wraps to temperature
  sequence an_b_done_s;
    cv_ff == pmw_pkg::CV_BUSY && conv_done && conv_src_ff == `PMW_SRC_AN_B;
  endsequence
  an_b_store_a: assert property (an_b_done_s
      |=> res_ff[`PMW_SRC_AN_B] == $past(conv_data) && conv_src_ff == `PMW_SRC_DIE_TEMP)
    else $error("second analog result not stored");
endmodule : pmw_i2c_pacing

// file: sim/pmw_master.sv
// bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module pmw_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  // clock stands high and data is released outside frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // one 800 ns bit: data set early in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(1);
    sda_oe = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(1);
  endtask : bit_io
  task automatic start();
    sda_oe = 1'b1;
    tick(4);
  endtask : start
  task automatic stop();
    scl = 1'b0;
    tick(1);
    sda_oe = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask : stop
  // msb first, ninth bit released so the device can acknowledge
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_io
endmodule : pmw_master

// file: sim/testbench.sv
// self-checking bench for the setpoint pacing register port
`timescale 1ns/1ps
`include "pmw_defs.svh"
module testbench;
  localparam int PACE = 400;
  logic                          mclk = 1'b0;
  logic                          sys_rst = 1'b1;
  logic                          scl, m_oe, sda_oe, sda_out, conv_cal, conv_start, ok, cbusy, ccal, hold;
  logic [1:0]                    conv_src, src;
  logic [`PMW_NUM_OUT-1:0]       pg_raw = 5'h1f;
  logic [`PMW_NUM_OUT-1:0]       power_ok;
  logic [`PMW_NUM_OUT-1:0][7:0]  vout_level;
  logic                          conv_done = 1'b0;
  logic [7:0]                    conv_data = 8'h00;
  logic [7:0]                    d, cd, rx, exp_res [3];
  int                            fails, checks, seed, cnt, i;
  wire                           sda = ~(sda_oe | m_oe);  // pull-up on the data line
  always #50 mclk = ~mclk;
  pmw_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  pmw_i2c_pacing #(.PACE_CYC(PACE)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out_ff(sda_out), .sda_oe_ff(sda_oe),
    .pg_raw(pg_raw), .output_power_ok(power_ok), .vout_level(vout_level), .conv_cal_ff(conv_cal),
    .conv_start_ff(conv_start), .conv_src_ff(conv_src), .conv_done(conv_done), .conv_data(conv_data));
  // converter model: random latency and data, remembers each source's last result
  always @(posedge mclk) begin
    conv_done <= #1 1'b0;
    if (sys_rst) begin
      cbusy <= 1'b0;
      hold <= 1'b0;
    end else if (cbusy) begin
      cnt <= cnt - 1;
      if (cnt == 0) begin
        cd = 8'($random(seed));  // own variable, the main sequence keeps d
        cbusy <= 1'b0;
        hold <= 1'b1;
        conv_done <= #1 1'b1;
        conv_data <= #1 cd;
        if (!ccal) exp_res[src] <= cd;
      end
    end else if (hold) hold <= 1'b0;
    else if (conv_cal | conv_start) begin
      cbusy <= 1'b1;
      cnt <= $unsigned($random(seed)) % 8;
      src <= conv_src;
      ccal <= conv_cal;
    end
  end
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v, output logic ack);
    logic [7:0] r;
    logic       k;
    m.start();
    m.byte_io({`PMW_I2C_ADDR, 1'b0}, r, k);
    m.byte_io(a, r, k);
    m.byte_io(v, r, ack);
    m.stop();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] r;
    logic       k;
    m.start();
    m.byte_io({`PMW_I2C_ADDR, 1'b0}, r, k);
    m.byte_io(a, r, k);
    m.stop();
    m.start();
    m.byte_io({`PMW_I2C_ADDR, 1'b1}, r, k);
    m.byte_io(8'hff, v, k);
    m.stop();
  endtask : reg_rd
  // watchdog for anything that hangs
  initial begin
    #5_000_000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    seed = 94238;
    repeat (4) @(posedge mclk);
    #1;
    chk_bit(conv_cal, 1'b1, "calibrate at power-up");
    chk_byte(vout_level[0], `PMW_LIN_SP_RST, "linear reset level");
    for (int j = 1; j < `PMW_NUM_OUT; j++) chk_byte(vout_level[j], `PMW_SW_SP_RST, "switcher reset level");
    sys_rst = 1'b0;
    m.tick(3);
    reg_rd(`PMW_REG_CONV_EN, rx);
    chk_byte(rx, 8'h01, "converter enable default");
    reg_rd(`PMW_REG_SP_FIRST, rx);
    chk_byte(rx, `PMW_LIN_SP_RST, "setpoint default");
    reg_rd(8'h05, rx);
    chk_byte(rx, 8'h00, "unmapped read");
    m.start();
    m.byte_io(8'h58, rx, ok);
    m.stop();
    chk_bit(ok, 1'b0, "foreign address ignored");
    // freeze the converter, then read the three results
    reg_wr(`PMW_REG_CONV_EN, 8'h00, ok);
    m.tick(30);
    reg_rd(`PMW_REG_DIE_TEMP, rx);
    chk_byte(rx, exp_res[`PMW_SRC_DIE_TEMP], "temperature code");
    reg_rd(`PMW_REG_AN_A, rx);
    chk_byte(rx, exp_res[`PMW_SRC_AN_A], "input a result");
    reg_rd(`PMW_REG_AN_B, rx);
    chk_byte(rx, exp_res[`PMW_SRC_AN_B], "input b result");
    reg_wr(`PMW_REG_CONV_EN, 8'h01, ok);
    // random pacing rounds on the linear output, small steps on switcher 1
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      pg_raw = 5'($random(seed));
      reg_wr(`PMW_REG_SP_FIRST, d, ok);
      chk_bit(ok, 1'b1, "first write taken");
      reg_wr(`PMW_REG_SP_FIRST, ~d, ok);
      chk_bit(ok, 1'b0, "early rewrite refused");
      reg_rd(`PMW_REG_SP_FIRST, rx);
      chk_byte(rx, d, "refused write kept value");
      chk_byte(vout_level[0], d, "linear level");
      chk_bit(power_ok[0], pg_raw[0], "power ok follows comparator");
      reg_rd(`PMW_REG_STATUS, rx);
      chk_byte(rx, {3'h0, pg_raw}, "status power ok");
      reg_wr(8'h11, 8'(k + 1), ok);
      chk_bit(ok, 1'b1, "other output independent");
      repeat (PACE) @(posedge mclk);
      #1;
      reg_wr(`PMW_REG_SP_FIRST, ~d, ok);
      chk_bit(ok, 1'b1, "rewrite after window");
      repeat (PACE) @(posedge mclk);
      #1;
    end
    // long ramp on switcher 1
    pg_raw[1] = 1'b0;
    reg_wr(8'h11, 8'hff, ok);
    chk_bit(ok, 1'b1, "ramp write taken");
    chk_bit(vout_level[1] == 8'hff, 1'b0, "no instant step");
    chk_bit(power_ok[1], 1'b1, "power ok blanked");
    repeat (PACE) @(posedge mclk);
    #1;
    reg_wr(8'h11, 8'h10, ok);
    chk_bit(ok, 1'b0, "refused while ramping");
    reg_rd(8'h11, rx);
    chk_byte(rx, 8'hff, "ramp target kept");
    for (i = 0; i < 10000 && vout_level[1] !== 8'hff; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 10000) begin
      fails++;
      $display("[FAIL] %0t ramp never finished", $time);
    end else begin
      m.tick(5);
      chk_bit(power_ok[1], 1'b0, "power ok re-evaluated");
      // fine switcher: eight codes at the short step period
      reg_wr(8'h14, 8'h08, ok);
      chk_bit(ok, 1'b1, "fine switcher write taken");
      m.tick(60);
      chk_byte(vout_level[4], 8'h08, "fine ramp reached target");
      chk_bit(sda_out, 1'b0, "data pin output value low");
    end
    end_of_test();
  end
endmodule : testbench
